// ---- src/afu_decoder.sv ----
`timescale 1ns/10ps
`include "afu_consts.svh"

module afu_decoder
  import afu_pkg::*;
(
  input  wire logic       mclk,      // system clock
  input  wire logic       rst_n,     // async reset, active low
  input  wire logic       in_valid,  // byte present this cycle
  input  wire logic       in_first,  // byte is first of field
  input  wire logic       in_last,   // byte is last of field
  input  wire logic [7:0] in_byte,   // field byte
  output logic            out_valid, // character strobe
  output afu_char_s       out_char,  // decoded character
  output logic            out_end,   // end of field strobe
  output logic            busy       // inside a field
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  afu_state_e  state;
  afu_state_e  next_state;
  logic [7:0]  count;
  logic [7:0]  next_count;
  logic [7:0]  msb;
  logic [15:0] base;
  logic        emit;
  afu_char_s   emit_ch;
  logic        fin;
  afu_char_s   map_ch;

  // --------------------------------------------------------------------
  // byte decode
  // --------------------------------------------------------------------
  wire       start      = in_valid & in_first;
  wire       take       = in_valid & ~in_first;
  wire       is_pad     = in_byte == `AFU_PAD;
  wire       tag_direct = in_byte == `AFU_TAG_DIRECT;
  wire       tag_half8  = in_byte == `AFU_TAG_HALF8;
  wire       tag_half16 = in_byte == `AFU_TAG_HALF16;
  wire       cnt_zero   = in_byte == `AFU_CNT_ZERO;
  wire       cnt_last   = count == `AFU_CNT_ONE;
  wire       pair_pad   = (msb == `AFU_PAD) & is_pad;
  wire [15:0] base8     = {`AFU_HP_TOP, in_byte, `AFU_HP_LOW};
  afu_char_s gsm_ch;
  assign gsm_ch.ucs2 = 1'b0;
  assign gsm_ch.code = {`AFU_OFS_PAD, in_byte[`AFU_OFS_MSB:0]};

  afu_char_map u_map (
    .base      (base),
    .code_byte (in_byte),
    .ch        (map_ch)
  );

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    emit       = 1'b0;
    emit_ch    = map_ch;
    fin        = 1'b0;
    if (start) begin
      // a new first byte always restarts, abandoning a broken field
      if (tag_direct) begin
        next_state = AFU_S_DIR_HI;
      end else if (tag_half8) begin
        next_state = AFU_S_CNT8;
      end else if (tag_half16) begin
        next_state = AFU_S_CNT16;
      end else if (is_pad) begin
        next_state = AFU_S_IDLE;
        fin        = 1'b1;
      end else begin
        emit       = 1'b1;
        emit_ch    = gsm_ch;
        next_state = AFU_S_GSM;
      end
    end else if (take) begin
      case (state)
        AFU_S_IDLE: begin
          next_state = AFU_S_IDLE;
        end
        AFU_S_GSM: begin
          if (is_pad) begin
            next_state = AFU_S_IDLE;
            fin        = 1'b1;
          end else begin
            emit    = 1'b1;
            emit_ch = gsm_ch;
          end
        end
        AFU_S_DIR_HI: begin
          next_state = AFU_S_DIR_LO;
        end
        AFU_S_DIR_LO: begin
          if (pair_pad) begin
            next_state = AFU_S_IDLE;
            fin        = 1'b1;
          end else begin
            emit         = 1'b1;
            emit_ch.ucs2 = 1'b1;
            emit_ch.code = {msb, in_byte};
            next_state   = AFU_S_DIR_HI;
          end
        end
        AFU_S_CNT8, AFU_S_CNT16: begin
          next_count = in_byte;
          if (cnt_zero) begin
            next_state = AFU_S_IDLE;
            fin        = 1'b1;
          end else begin
            next_state = (state == AFU_S_CNT8) ? AFU_S_BASE8 : AFU_S_BASEH;
          end
        end
        AFU_S_BASE8: begin
          next_state = AFU_S_OFS;
        end
        AFU_S_BASEH: begin
          next_state = AFU_S_BASEL;
        end
        AFU_S_BASEL: begin
          next_state = AFU_S_OFS;
        end
        AFU_S_OFS: begin
          // FF inside the count is a real offset, never padding
          emit       = 1'b1;
          next_count = count - `AFU_CNT_ONE;
          if (cnt_last) begin
            next_state = AFU_S_IDLE;
            fin        = 1'b1;
          end
        end
        default: begin
          next_state = AFU_S_IDLE;
        end
      endcase
    end
    // a field that stops early still closes with an end strobe
    if (in_valid && in_last && next_state != AFU_S_IDLE) begin
      next_state = AFU_S_IDLE;
      fin        = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  wire ld_msb   = take & (state == AFU_S_DIR_HI);
  wire ld_base8 = take & (state == AFU_S_BASE8);
  wire ld_baseh = take & (state == AFU_S_BASEH);
  wire ld_basel = take & (state == AFU_S_BASEL);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= AFU_S_IDLE;
      count <= `AFU_CNT_ZERO;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      msb  <= `AFU_CNT_ZERO;
      base <= {`AFU_CNT_ZERO, `AFU_CNT_ZERO};
    end else begin
      if (ld_msb) msb <= in_byte;
      if (ld_base8) base <= base8;
      if (ld_baseh) base[15:8] <= in_byte;
      if (ld_basel) base[7:0] <= in_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_char  <= '0;
      out_end   <= 1'b0;
      busy      <= 1'b0;
    end else begin
      out_valid <= emit;
      out_char  <= emit_ch;
      out_end   <= fin;
      busy      <= next_state != AFU_S_IDLE;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_dir_pair;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_DIR_LO && !pair_pad) |=>
        (out_valid && out_char.ucs2 && out_char.code == {$past(msb), $past(in_byte)});
  endproperty
  a_dir_pair: assert property (p_dir_pair) else $error("direct pair wrong");

  property p_count_load;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_CNT8) |=> (count == $past(in_byte));
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");

  property p_base8;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_BASE8) |=> (base == {1'b0, $past(in_byte), 7'h00});
  endproperty
  a_base8: assert property (p_base8) else $error("8-bit base wrong");

  property p_gsm_char;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_OFS && !in_byte[7]) |=>
        (out_valid && !out_char.ucs2 && out_char.code == {9'h000, $past(in_byte[6:0])});
  endproperty
  a_gsm_char: assert property (p_gsm_char) else $error("alphabet char wrong");

  property p_base16;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_BASEH) ##1 (take && state == AFU_S_BASEL) |=>
        (base == {$past(in_byte, 2), $past(in_byte)});
  endproperty
  a_base16: assert property (p_base16) else $error("16-bit base wrong");

  property p_ofs_char;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_OFS && in_byte[7]) |=>
        (out_valid && out_char.ucs2 &&
         out_char.code == $past(base) + {9'h000, $past(in_byte[6:0])});
  endproperty
  a_ofs_char: assert property (p_ofs_char) else $error("offset char wrong");

  property p_forms;
    @(posedge mclk) disable iff (!rst_n)
      (start && !in_last && (tag_direct || tag_half8 || tag_half16)) |=>
        (busy && !out_valid && !out_end &&
         (state == AFU_S_DIR_HI || state == AFU_S_CNT8 || state == AFU_S_CNT16));
  endproperty
  a_forms: assert property (p_forms) else $error("form not accepted");

  property p_count_end;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_OFS && cnt_last) |=> (out_valid && out_end && !busy);
  endproperty
  a_count_end: assert property (p_count_end) else $error("count end missed");

  property p_ff_valid;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_OFS && is_pad) |=> out_valid;
  endproperty
  a_ff_valid: assert property (p_ff_valid) else $error("FF dropped in count");

  property p_pad_end;
    @(posedge mclk) disable iff (!rst_n)
      (take && state == AFU_S_DIR_LO && pair_pad) |=> (out_end && !out_valid && !busy);
  endproperty
  a_pad_end: assert property (p_pad_end) else $error("padding end missed");

endmodule : afu_decoder

// ---- src/afu_consts.svh ----
`ifndef AFU_CONSTS_SVH
`define AFU_CONSTS_SVH

// ----------------------------------------------------------------------
// field header tags and padding
// ----------------------------------------------------------------------
`define AFU_TAG_DIRECT 8'h80
`define AFU_TAG_HALF8  8'h81
`define AFU_TAG_HALF16 8'h82
`define AFU_PAD        8'hFF

// ----------------------------------------------------------------------
// counts and field positions
// ----------------------------------------------------------------------
`define AFU_CNT_ZERO   8'h00
`define AFU_CNT_ONE    8'h01
`define AFU_SEL_BIT    7
`define AFU_OFS_MSB    6
`define AFU_OFS_PAD    9'h000
`define AFU_HP_TOP     1'h0
`define AFU_HP_LOW     7'h00

`endif

// ---- src/afu_pkg.sv ----
package afu_pkg;

  // --------------------------------------------------------------------
  // decoded character carrier
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        ucs2;
    logic [15:0] code;
  } afu_char_s;

  // --------------------------------------------------------------------
  // decoder states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    AFU_S_IDLE   = 4'h0,
    AFU_S_GSM    = 4'h1,
    AFU_S_DIR_HI = 4'h2,
    AFU_S_DIR_LO = 4'h3,
    AFU_S_CNT8   = 4'h4,
    AFU_S_BASE8  = 4'h5,
    AFU_S_CNT16  = 4'h6,
    AFU_S_BASEH  = 4'h7,
    AFU_S_BASEL  = 4'h8,
    AFU_S_OFS    = 4'h9
  } afu_state_e;

endpackage : afu_pkg

// ---- src/afu_char_map.sv ----
`timescale 1ns/10ps
`include "afu_consts.svh"

module afu_char_map
  import afu_pkg::*;
(
  input  wire logic [15:0] base,      // half-page base pointer
  input  wire logic [7:0]  code_byte, // one character byte
  output afu_char_s        ch         // mapped character
);

  // --------------------------------------------------------------------
  // clear top bit: default alphabet, set: base plus offset
  // --------------------------------------------------------------------
  wire        sel_ucs2 = code_byte[`AFU_SEL_BIT];
  wire [15:0] offset   = {`AFU_OFS_PAD, code_byte[`AFU_OFS_MSB:0]};
  wire [15:0] sum      = base + offset;

  assign ch.ucs2 = sel_ucs2;
  assign ch.code = sel_ucs2 ? sum : offset;

endmodule : afu_char_map

// ---- dv/afu_src_model.sv ----
`timescale 1ns/10ps

module afu_src_model (
  input  wire logic mclk,     // system clock
  output logic      in_valid, // byte present
  output logic      in_first, // first byte of field
  output logic      in_last,  // last byte of field
  output logic [7:0] in_byte  // field byte
);
  logic [7:0] q[$];

  initial begin
    in_valid = 1'b0;
    in_first = 1'b0;
    in_last  = 1'b0;
    in_byte  = 8'h00;
  end

  // ----------------------------------------------------------------------
  // byte source, random idle gaps
  // ----------------------------------------------------------------------
  task automatic play(input int gap_max);
    int n;
    int i;
    n = q.size();
    for (i = 0; i < n; i++) begin
      repeat ($urandom_range(gap_max)) begin
        @(negedge mclk);
        in_valid = 1'b0;
        in_byte  = ~in_byte; // idle byte inverts every idle cycle, so it differs from the byte of the cycle before
      end
      @(negedge mclk);
      in_valid = 1'b1;
      in_first = (i == 0);
      in_last  = (i == n - 1);
      in_byte  = q[i];
    end
    @(negedge mclk);
    in_valid = 1'b0;
    in_first = 1'b0;
    in_last  = 1'b0;
    in_byte  = ~in_byte;
    q.delete();
  endtask : play
endmodule : afu_src_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps

module testbench
  import afu_pkg::*;
;
  logic       mclk;
  logic       rst_n;
  logic       in_valid;
  logic       in_first;
  logic       in_last;
  logic [7:0] in_byte;
  logic       out_valid;
  afu_char_s  out_char;
  logic       out_end;
  logic       busy;
  logic [7:0] fld[$];
  afu_char_s  exp_q[$];
  int         ends;
  int         failures;
  int         checks;

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  afu_src_model u_afu_src_model (.mclk(mclk), .in_valid(in_valid), .in_first(in_first),
                                 .in_last(in_last), .in_byte(in_byte));
  afu_decoder u_afu_decoder (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid),
                             .in_first(in_first), .in_last(in_last), .in_byte(in_byte),
                             .out_valid(out_valid), .out_char(out_char),
                             .out_end(out_end), .busy(busy));

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------------
  // expectation
  // ----------------------------------------------------------------------
  function automatic afu_char_s mk(input logic [15:0] base, input logic [7:0] b);
    afu_char_s c;
    c.ucs2 = b[7];
    c.code = b[7] ? base + {9'h000, b[6:0]} : {9'h000, b[6:0]};
    return c;
  endfunction : mk

  function automatic void predict();
    int i;
    int cnt;
    cnt = int'(fld[1]);
    case (fld[0])
      8'h80: for (i = 1; i + 1 < fld.size(); i += 2) begin
        if ({fld[i], fld[i+1]} == 16'hFFFF) break;
        exp_q.push_back({1'b1, fld[i], fld[i+1]});
      end
      8'h81: for (i = 0; i < cnt && 3 + i < fld.size(); i++) begin
        exp_q.push_back(mk({1'b0, fld[2], 7'h00}, fld[3+i]));
      end
      8'h82: for (i = 0; i < cnt && 4 + i < fld.size(); i++) begin
        exp_q.push_back(mk({fld[2], fld[3]}, fld[4+i]));
      end
      default: for (i = 0; i < fld.size(); i++) begin
        if (fld[i] == 8'hFF) break;
        exp_q.push_back({1'b0, 9'h000, fld[i][6:0]});
      end
    endcase
  endfunction : predict

  always @(negedge mclk) begin
    if (out_valid === 1'b1) begin
      chk({15'h0, out_char}, exp_q.size() ? {15'h0, exp_q.pop_front()} : 32'hDEAD0000);
    end
    if (out_end === 1'b1) begin
      ends++;
      chk({31'h0, busy}, 32'h0);
    end else if (out_valid === 1'b1) begin
      chk({31'h0, busy}, 32'h1);
    end
  end

  // ----------------------------------------------------------------------
  // field runner
  // ----------------------------------------------------------------------
  task automatic run(input int gap);
    int t;
    ends = 0;
    predict();
    u_afu_src_model.q = fld;
    u_afu_src_model.play(gap);
    t = 0;
    while ((exp_q.size() != 0 || ends == 0) && t < 50) begin
      @(negedge mclk);
      t++;
    end
    if (exp_q.size() != 0 || ends == 0) begin
      failures++;
      close_out();
    end
    repeat (2) @(negedge mclk);
    chk(32'(ends), 32'h1);
    chk(32'(exp_q.size()), 32'h0);
    chk({31'h0, busy}, 32'h0);
    fld.delete();
  endtask : run

  task automatic rnd_field(input logic [7:0] tag);
    int n;
    int i;
    n = $urandom_range(6);
    if (tag == 8'h80) begin
      fld.push_back(tag);
      for (i = 0; i < 2 * n; i++) fld.push_back(8'($urandom_range(254)));
      fld.push_back(8'hFF);
      fld.push_back(8'hFF);
    end else if (tag[7]) begin
      fld.push_back(tag);
      fld.push_back(8'(n));
      fld.push_back(8'($urandom_range(255)));
      if (tag == 8'h82) fld.push_back(8'($urandom_range(255)));
      for (i = 0; i < n; i++) begin
        // the last char is an offset char: a pure alphabet record may not use a half-page form
        fld.push_back(8'($urandom_range(255)) | ((i == n - 1) ? 8'h80 : 8'h00));
      end
    end else begin
      for (i = 0; i <= n; i++) fld.push_back(8'($urandom_range(126)));
      fld.push_back(8'hFF);
    end
  endtask : rnd_field

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int k;
    rst_n = 1'b0;
    void'($urandom(32'h0422));
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    fld = '{8'h81, 8'h02, 8'h13, 8'h53, 8'h95};
    run(0);
    fld = '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31};
    run(1);
    fld = '{8'h81, 8'h03, 8'h13, 8'hFF, 8'h7F, 8'h80};
    run(0);
    fld = '{8'h80, 8'h04, 8'h1F, 8'hFF};
    run(0);
    fld = '{8'h81, 8'h00};
    run(0);
    fld = '{8'h82, 8'h05, 8'hFF, 8'hF0, 8'hA5};
    run(2);
    for (k = 0; k < 60; k++) begin
      rnd_field(k % 4 == 3 ? 8'h00 : 8'h80 + 8'(k % 4));
      run(k % 3);
    end
    close_out();
  end
endmodule : testbench
